//--- hw/mst_params.svh
// Offsets, field positions, reset values and figures of the translator.
// Assumes a byte-addressed Avalon-MM slave with one 32-bit word per register.
`ifndef MST_PARAMS_SVH
`define MST_PARAMS_SVH

// Register byte offsets
`define MST_OFS_CTRL        4'h0
`define MST_OFS_STATUS      4'h4
`define MST_OFS_COIL        4'h8

// Control register fields
`define MST_CTRL_RES_LSB    0
`define MST_CTRL_POL_BIT    3
`define MST_CTRL_ENABLE_BIT 4
`define MST_CTRL_SOFT_BIT   5

// Status register fields
`define MST_STAT_POS_LSB    0
`define MST_STAT_DIRPIN_BIT 8
`define MST_STAT_RES_LSB    9

// Coil register fields
`define MST_COIL_X_LSB      0
`define MST_COIL_Y_LSB      16

// Reset values and figures
`define MST_RESET_POS       7'h10
`define MST_RESET_RES       3'h0
`define MST_RES_FULL2       3'h7
`define MST_RES_FINEST_HALF 3'h4
`define MST_FULL2_OFFSET    7'h10
`define MST_FULL_STEP       7'h20
`define MST_FULL_DIAG       11'sh2c6
`define MST_SINE_DIAG       11'sh2c3

`endif

//--- hw/mst_pkg.sv
// Types shared by the translator: control word, coil pair and step modes.
// Assumes the constants header is included by the design file.
package mst_pkg;

	// Software control fields
	typedef struct packed {
		logic       soft_step_bit;
		logic       motor_drive_enable_bit;
		logic       direction_polarity_bit;
		logic [2:0] step_resolution_select;
	} mst_ctrl_type;

	// Signed coil currents in tenths of a percent
	typedef struct packed {
		logic signed [10:0] coil_y;
		logic signed [10:0] coil_x;
	} mst_coil_type;

	typedef enum logic [1:0] {
		MST_MODE_MICRO,
		MST_MODE_FULL1,
		MST_MODE_FULL2
	} mst_mode_type;

endpackage : mst_pkg

//--- hw/mst_translator.sv
// Micro-step current translator with an Avalon-MM register slave.
// Assumes pins are synchronous to clk_sys and a master that honours waitrequest.
//
// How it works
// (RULE_01) Position is a 7-bit count of 1/32 micro-steps, readable by software.
// (RULE_02) Software reads the position field in the status register at any time.
// (RULE_03) Position changes on the same edge that takes the step trigger.
// (RULE_04) Micro-step modes map position to sine Y and cosine X coil currents.
// (RULE_05) Resolutions 000..100 visit multiples of 1, 2, 4, 8, 16.
// (RULE_06) Codes 101 and 110 step positions 0, 32, 64, 96: one coil on.
// (RULE_07) Code 111 steps positions 16, 48, 80, 112, both coils at 71 percent.
// (RULE_08) Full-step modes output 100, 71 or 0 percent with square signs.
// (RULE_09) Micro to full-step changes use the same clearing and nearest rules.
// (RULE_10) Full-step mode swaps move 45 degrees by direction, on the next trigger.
// (RULE_11) Effective direction is direction pin XOR polarity bit.
// (RULE_12) Positive direction advances the position, counter-clockwise vector.
// (RULE_13) Direction and stepping work even with the drive enable bit cleared.
// (RULE_14) The sampled direction pin level is a status flag.
// (RULE_15) Position wraps modulo 128 in both directions.
// (RULE_16) Reset gives 1/32 resolution at position 16.
// (RULE_17) Effective resolution is serial field plus the two offset pins.
// (RULE_18) Lowering resolution clears low bits, else nearest point by direction.
// (RULE_19) A pin rising edge or soft bit steps once; soft bit self-clears.
//
// The register offsets and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
`include "mst_params.svh"

module mst_translator #(
	// Position width; the tables and the step arithmetic are built for 7 bits
	parameter int POS_W = 7
) (
	input  wire logic                   clk_sys,
	input  wire logic                   reset,
	input  wire logic [3:0]             avs_address,
	input  wire logic                   avs_read,
	input  wire logic                   avs_write,
	input  wire logic [31:0]            avs_writedata,
	input  wire logic [3:0]             avs_byteenable,
	output logic      [31:0]            avs_readdata,
	output logic                        avs_waitrequest,
	input  wire logic                   next_step_pin,
	input  wire logic                   direction_pin,
	input  wire logic                   resolution_offset_pin0,
	input  wire logic                   resolution_offset_pin1,
	output logic      [POS_W-1:0]       translator_position,
	output mst_pkg::mst_coil_type       coil_current,
	output logic                        drive_enable,
	output logic                        rotation_positive
);

	// Quarter-wave sine in tenths of a percent, index 0..32
	// Entries are rounded to the nearest tenth; index 32 is the peak of 1000.
	// A case table folds into gates, cheaper than a 33-word store here,
	// and one quarter of the circle is all that has to be kept.
	function automatic logic signed [10:0] sine_quarter(input logic [5:0] idx);
		logic signed [10:0] v;
		v = 11'sh000;
		case (idx)
			6'h00: v = 11'sd0;
			6'h01: v = 11'sd49;
			6'h02: v = 11'sd98;
			6'h03: v = 11'sd147;
			6'h04: v = 11'sd195;
			6'h05: v = 11'sd243;
			6'h06: v = 11'sd290;
			6'h07: v = 11'sd337;
			6'h08: v = 11'sd383;
			6'h09: v = 11'sd428;
			6'h0a: v = 11'sd471;
			6'h0b: v = 11'sd514;
			6'h0c: v = 11'sd556;
			6'h0d: v = 11'sd596;
			6'h0e: v = 11'sd634;
			6'h0f: v = 11'sd672;
			6'h10: v = 11'sd707;
			6'h11: v = 11'sd741;
			6'h12: v = 11'sd773;
			6'h13: v = 11'sd803;
			6'h14: v = 11'sd831;
			6'h15: v = 11'sd858;
			6'h16: v = 11'sd882;
			6'h17: v = 11'sd904;
			6'h18: v = 11'sd924;
			6'h19: v = 11'sd942;
			6'h1a: v = 11'sd957;
			6'h1b: v = 11'sd970;
			6'h1c: v = 11'sd981;
			6'h1d: v = 11'sd989;
			6'h1e: v = 11'sd995;
			6'h1f: v = 11'sd999;
			default: v = 11'sd1000;
		endcase
		return v;
	endfunction : sine_quarter

	// Full-circle sine by quadrant symmetry; cosine is sine a quarter ahead
	// Bit 5 mirrors the quarter and bit 6 flips the sign, so all 128 points
	// cost one table and a negation.
	function automatic logic signed [10:0] sine_of(input logic [6:0] pos);
		logic [5:0]         r;
		logic [5:0]         rr;
		logic signed [10:0] m;
		r  = {1'b0, pos[4:0]};
		rr = 6'h20 - r;
		m  = pos[5] ? sine_quarter(rr) : sine_quarter(r);
		return pos[6] ? -m : m;
	endfunction : sine_of

	// Square table keeps the signs but lifts the diagonal to 71 percent
	// The axis points are the same 100 and 0 in both tables, so only the
	// diagonal needs a value of its own.
	function automatic logic signed [10:0] square_of(input logic signed [10:0] v);
		logic signed [10:0] s;
		s = v;
		if (v == `MST_SINE_DIAG) begin
			s = `MST_FULL_DIAG;
		end else if (v == -`MST_SINE_DIAG) begin
			s = -`MST_FULL_DIAG;
		end
		return s;
	endfunction : square_of

	// Step mode from an effective resolution code
	// Codes 5 and 6 give the same mode, so the spare code costs nothing.
	function automatic mst_pkg::mst_mode_type mode_of(input logic [2:0] res);
		mst_pkg::mst_mode_type m;
		if (res <= `MST_RES_FINEST_HALF) begin
			m = mst_pkg::MST_MODE_MICRO;
		end else if (res == `MST_RES_FULL2) begin
			m = mst_pkg::MST_MODE_FULL2;
		end else begin
			m = mst_pkg::MST_MODE_FULL1;
		end
		return m;
	endfunction : mode_of

	// Next grid point in the direction of rotation; 7-bit sums wrap mod 128
	// The grid is shifted by the offset so that every mode steps on multiples
	// of its pitch. A position on the grid moves one pitch; one left off the
	// grid by a change to a coarser mode lands on the nearest grid point in
	// the direction of rotation. The same path yields the half-pitch move
	// between the two full-step modes, so that move needs no case of its own.
	function automatic logic [6:0] step_from(
		input logic [6:0] pos,
		input logic [2:0] res,
		input logic       fwd
	);
		logic [6:0] pitch;
		logic [6:0] offset;
		logic [6:0] rel;
		logic [6:0] floor_rel;
		mst_pkg::mst_mode_type m;
		m = mode_of(res);
		unique case (m)
			mst_pkg::MST_MODE_MICRO: begin
				pitch  = 7'(7'h01 << res); // RULE_05
				offset = 7'h00;
			end
			mst_pkg::MST_MODE_FULL1: begin
				pitch  = `MST_FULL_STEP; // RULE_06
				offset = 7'h00;
			end
			mst_pkg::MST_MODE_FULL2: begin
				pitch  = `MST_FULL_STEP; // RULE_07
				offset = `MST_FULL2_OFFSET; // RULE_10
			end
		endcase
		rel       = 7'(pos - offset);
		floor_rel = rel & ~7'(pitch - 7'h01); // RULE_18 RULE_09
		if (floor_rel == rel) begin
			rel = fwd ? 7'(rel + pitch) : 7'(rel - pitch); // RULE_12 RULE_15
		end else begin
			rel = fwd ? 7'(floor_rel + pitch) : floor_rel; // RULE_18 RULE_10
		end
		return 7'(rel + offset);
	endfunction : step_from

	// State held besides the registered outputs
	mst_pkg::mst_ctrl_type ctrl;
	logic [2:0]            applied_res;
	logic                  step_pin_prev;
	logic                  dir_pin_seen;

	// Effective resolution saturates at the top code
	// A sum past 7 would wrap to a fine mode; saturating keeps the coarsest.
	wire logic [3:0] res_sum    = {1'b0, ctrl.step_resolution_select}
		+ {2'b00, resolution_offset_pin1, resolution_offset_pin0}; // RULE_17
	wire logic [2:0] eff_res    = res_sum[3] ? `MST_RES_FULL2 : res_sum[2:0];
	wire logic       eff_fwd    = direction_pin ^ ctrl.direction_polarity_bit; // RULE_11

	// Trigger: pin edge has priority, a pending soft step waits one cycle
	wire logic       pin_edge   = next_step_pin & ~step_pin_prev; // RULE_19
	wire logic       soft_take  = ctrl.soft_step_bit & ~pin_edge;
	wire logic       trigger    = pin_edge | ctrl.soft_step_bit; // RULE_13

	// Bus decode
	// Only byte lane 0 carries control bits; a write without it is answered
	// but leaves the control word alone.
	wire logic       bus_req    = avs_read | avs_write;
	wire logic       bus_commit = bus_req & ~avs_waitrequest;
	wire logic       sel_ctrl   = avs_address == `MST_OFS_CTRL;
	wire logic       sel_status = avs_address == `MST_OFS_STATUS;
	wire logic       sel_coil   = avs_address == `MST_OFS_COIL;
	wire logic       wr_ctrl    = bus_commit & avs_write & sel_ctrl & avs_byteenable[0];

	// Next values of the translator
	// Coils use the resolution applied with the step, not the live one, so a
	// change of the offset pins or of the field alone never moves the currents.
	wire logic [6:0] next_position = trigger
		? step_from(translator_position, eff_res, eff_fwd) // RULE_03
		: translator_position;
	wire logic [2:0] next_applied_res = trigger ? eff_res : applied_res;
	wire logic signed [10:0] sin_raw = sine_of(next_position);
	wire logic signed [10:0] cos_raw = sine_of(7'(next_position + `MST_FULL_STEP));
	wire logic       next_square = mode_of(next_applied_res) != mst_pkg::MST_MODE_MICRO;
	wire logic signed [10:0] next_coil_y = next_square ? square_of(sin_raw) : sin_raw;
	wire logic signed [10:0] next_coil_x = next_square ? square_of(cos_raw) : cos_raw;

	// Soft step: a write that sets it beats the self-clear in the same cycle
	// A pin edge in the same cycle goes first and leaves the soft request
	// pending, so both triggers still give one step each.
	wire logic       next_soft = (wr_ctrl & avs_writedata[`MST_CTRL_SOFT_BIT])
		| (ctrl.soft_step_bit & ~soft_take); // RULE_19

	// Read mux; unmapped offsets read zero
	// The mux only has to settle within the wait state, as read data is registered.
	wire logic [31:0] status_word = (32'(translator_position) << `MST_STAT_POS_LSB) // RULE_02
		| (32'(dir_pin_seen) << `MST_STAT_DIRPIN_BIT) // RULE_14
		| (32'(applied_res) << `MST_STAT_RES_LSB);
	wire logic [31:0] coil_word = (32'(unsigned'(coil_current.coil_x)) << `MST_COIL_X_LSB)
		| (32'(unsigned'(coil_current.coil_y)) << `MST_COIL_Y_LSB);
	wire logic [31:0] next_readdata = sel_ctrl ? 32'(ctrl)
		: sel_status ? status_word
		: sel_coil ? coil_word
		: 32'h0000_0000;

	// One wait state per access; read data is captured with it
	// Waitrequest is high at idle, so no request is answered in the cycle it
	// appears; back-to-back accesses therefore take two cycles each.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else begin
			avs_waitrequest <= ~(bus_req & avs_waitrequest);
			avs_readdata    <= (avs_read & avs_waitrequest) ? next_readdata : avs_readdata;
		end
	end

	// Control fields; resolution steers only the next step, polarity the next step and rotation_positive
	// The soft bit runs every cycle because it clears itself after its step.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ctrl <= '{1'b0, 1'b0, 1'b0, `MST_RESET_RES}; // RULE_16
		end else begin
			if (wr_ctrl) begin
				ctrl.step_resolution_select <= avs_writedata[`MST_CTRL_RES_LSB +: 3];
				ctrl.direction_polarity_bit <= avs_writedata[`MST_CTRL_POL_BIT];
				ctrl.motor_drive_enable_bit <= avs_writedata[`MST_CTRL_ENABLE_BIT];
			end
			ctrl.soft_step_bit <= next_soft;
		end
	end

	// Translator state; prev starts high so a pin held high is no edge
	// The status flag shows the direction pin as it stood at the last clock,
	// while the step itself uses the live pin of the same cycle.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			translator_position <= `MST_RESET_POS; // RULE_16
			applied_res         <= `MST_RESET_RES;
			step_pin_prev       <= 1'b1;
			dir_pin_seen        <= 1'b0;
		end else begin
			translator_position <= next_position; // RULE_01 RULE_03
			applied_res         <= next_applied_res;
			step_pin_prev       <= next_step_pin;
			dir_pin_seen        <= direction_pin; // RULE_14
		end
	end

	// Coil currents follow the position on the same edge
	// Reset values are the currents of the reset position, on the diagonal.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			coil_current <= '{`MST_SINE_DIAG, `MST_SINE_DIAG};
		end else begin
			coil_current.coil_y <= next_coil_y; // RULE_04 RULE_08
			coil_current.coil_x <= next_coil_x; // RULE_04 RULE_08
		end
	end

	// Drive enable gates no stepping; effective direction is shown
	// Both are one clock behind the control word and the pin.
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			drive_enable      <= 1'b0;
			rotation_positive <= 1'b0;
		end else begin
			drive_enable      <= ctrl.motor_drive_enable_bit; // RULE_13
			rotation_positive <= eff_fwd; // RULE_11
		end
	end

endmodule : mst_translator

//--- verif/mst_translator_chk.sv
// Checker of the translator's bus timing, direction and step grid.
// Assumes it is bound to mst_translator and sees only its ports.
`timescale 1ns/1ps
module mst_translator_chk #(
	parameter int POS_W = 7
) (
	input wire logic                  clk_sys,
	input wire logic                  reset,
	input wire logic [3:0]            avs_address,
	input wire logic                  avs_read,
	input wire logic                  avs_write,
	input wire logic [31:0]           avs_writedata,
	input wire logic [3:0]            avs_byteenable,
	input wire logic [31:0]           avs_readdata,
	input wire logic                  avs_waitrequest,
	input wire logic                  next_step_pin,
	input wire logic                  direction_pin,
	input wire logic                  resolution_offset_pin0,
	input wire logic                  resolution_offset_pin1,
	input wire logic [POS_W-1:0]      translator_position,
	input wire mst_pkg::mst_coil_type coil_current,
	input wire logic                  drive_enable,
	input wire logic                  rotation_positive
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	logic [5:0] ctl;
	// Shadow of the control fields, taken at the write's completing edge
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) ctl <= 6'h00;
		else if (avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable[0])
			ctl <= avs_writedata[5:0];
	end
	// Offset pins add to the field; the sum saturates at the coarsest code
	wire [3:0]       res_sum = {1'b0, ctl[2:0]}
		+ {2'h0, resolution_offset_pin1, resolution_offset_pin0};
	wire [2:0]       res_eff = res_sum[3] ? 3'h7 : res_sum[2:0];
	wire             dir_eff = direction_pin ^ ctl[3];
	wire [POS_W-1:0] pos_nxt = dir_eff ? translator_position + 1'b1 : translator_position - 1'b1;
	a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest)
		else $error("access not answered after one wait state");
	a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_unmapped_zero: assert property (avs_read && !avs_waitrequest
		&& !(avs_address inside {4'h0, 4'h4, 4'h8}) |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_dir_xor: assert property (rotation_positive == $past(dir_eff))
		else $error("direction is not pin xor polarity");
	a_enable_copy: assert property (drive_enable == $past(ctl[4]))
		else $error("drive enable does not follow control");
	a_step_fine: assert property ($rose(next_step_pin) && res_eff == 3'h0
		|=> translator_position == $past(pos_nxt))
		else $error("fine step went wrong way or late");
	a_full1_grid: assert property ($rose(next_step_pin) && res_eff inside {3'h5, 3'h6}
		|=> translator_position[4:0] == 5'h00
		&& ((coil_current.coil_x == 11'sh000) != (coil_current.coil_y == 11'sh000)))
		else $error("full step one off grid");
	a_full2_grid: assert property ($rose(next_step_pin) && res_eff == 3'h7
		|=> translator_position[4:0] == 5'h10)
		else $error("full step two off grid");
	a_full2_coil: assert property ($rose(next_step_pin) && res_eff == 3'h7
		|=> coil_current.coil_x inside {11'sh2c6, 11'sh53a}
		&& coil_current.coil_y inside {11'sh2c6, 11'sh53a})
		else $error("full step two coil not 71 percent");
endmodule : mst_translator_chk
bind mst_translator mst_translator_chk #(.POS_W(POS_W)) mst_translator_chk_i (.clk_sys, .reset,
	.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
	.avs_waitrequest, .next_step_pin, .direction_pin, .resolution_offset_pin0,
	.resolution_offset_pin1, .translator_position, .coil_current, .drive_enable, .rotation_positive);

//--- verif/mst_mcu_model.sv
// Controller model: drives the step, direction and offset pins.
// Assumes the bench calls its tasks right after a rising clock edge.
`timescale 1ns/1ps
module mst_mcu_model (
	input  wire logic clk_sys,
	output logic      next_step_pin,
	output logic      direction_pin,
	output logic      resolution_offset_pin0,
	output logic      resolution_offset_pin1
);
	initial begin
		next_step_pin = 1'b0;
		direction_pin = 1'b0;
		{resolution_offset_pin1, resolution_offset_pin0} = 2'h0;
	end
	// One rising edge, then low for a sample so the next edge is seen apart
	task step();
		@(posedge clk_sys);
		next_step_pin <= 1'b1;
		@(posedge clk_sys);
		next_step_pin <= 1'b0;
		@(posedge clk_sys);
	endtask : step
	// Settings move a cycle before any step, never with it
	task pins(input logic d, input logic [1:0] o);
		@(posedge clk_sys);
		direction_pin <= d;
		{resolution_offset_pin1, resolution_offset_pin0} <= o;
	endtask : pins
endmodule : mst_mcu_model

//--- verif/mst_translator_test.sv
// Bench of the translator: bus tasks and step sequences with expected values.
// Assumes the checker is bound in and the controller model drives the pins.
`timescale 1ns/1ps
module mst_translator_test;
	logic                  clk_sys = 1'b0;
	logic                  reset = 1'b1;
	logic [3:0]            avs_address = 4'h0;
	logic                  avs_read = 1'b0;
	logic                  avs_write = 1'b0;
	logic [31:0]           avs_writedata = 32'h0;
	logic [31:0]           avs_readdata;
	logic                  avs_waitrequest;
	logic                  step_pin, dir, op0, op1, drive_enable, rotation_positive;
	logic [6:0]            translator_position;
	mst_pkg::mst_coil_type coil_current;
	int                    err_count = 0;
	int                    num_checks = 0;
	always #20 clk_sys = ~clk_sys;
	mst_mcu_model mst_mcu_model_i (.clk_sys(clk_sys), .next_step_pin(step_pin), .direction_pin(dir),
		.resolution_offset_pin0(op0), .resolution_offset_pin1(op1));
	mst_translator mst_translator_i (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.next_step_pin(step_pin), .direction_pin(dir), .resolution_offset_pin0(op0),
		.resolution_offset_pin1(op1), .translator_position(translator_position),
		.coil_current(coil_current), .drive_enable(drive_enable),
		.rotation_positive(rotation_positive));
	task close_out();
		if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : close_out
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Held until the edge that sees waitrequest low; one idle edge follows
	task wr(input logic [3:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'b1;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
		avs_write <= 1'b0;
		@(posedge clk_sys);
	endtask : wr
	task rdc(input logic [3:0] a, input logic [31:0] e);
		avs_address <= a;
		avs_read <= 1'b1;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
		chk("readdata", e, avs_readdata);
		avs_read <= 1'b0;
		@(posedge clk_sys);
	endtask : rdc
	task stp(input logic [6:0] e);
		mst_mcu_model_i.step();
		chk("position", 32'(e), 32'(translator_position));
	endtask : stp
	// Watchdog: the sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk_sys);
		err_count++;
		close_out();
	end
	initial begin
		repeat (20) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		rdc(4'h4, 32'h00000010);
		rdc(4'h8, 32'h02c302c3);
		mst_mcu_model_i.pins(1'b1, 2'h0);
		stp(7'h11);
		rdc(4'h4, 32'h00000111);
		chk("rotation_positive", 32'h1, 32'(rotation_positive));
		wr(4'h0, 32'h1);
		stp(7'h12);
		wr(4'h0, 32'h4);
		for (int i = 1; i <= 7; i++) stp(7'(16 * i + 16));
		rdc(4'h8, 32'h000003e8);
		wr(4'h0, 32'hc);
		stp(7'h70);
		chk("rotation_positive", 32'h0, 32'(rotation_positive));
		rdc(4'h8, 32'h053d02c3);
		mst_mcu_model_i.pins(1'b1, 2'h1);
		stp(7'h60);
		rdc(4'h8, 32'h04180000);
		mst_mcu_model_i.pins(1'b1, 2'h3);
		stp(7'h50);
		rdc(4'h8, 32'h053a053a);
		wr(4'h0, 32'h4);
		stp(7'h70);
		stp(7'h10);
		stp(7'h30);
		rdc(4'h8, 32'h02c6053a);
		chk("coil_x", 32'h53a, 32'(unsigned'(coil_current.coil_x)));
		mst_mcu_model_i.pins(1'b1, 2'h0);
		wr(4'h0, 32'h20);
		rdc(4'h0, 32'h0);
		rdc(4'h4, 32'h00000131);
		chk("drive_enable", 32'h0, 32'(drive_enable));
		wr(4'h0, 32'h10);
		repeat (2) @(posedge clk_sys);
		chk("drive_enable", 32'h1, 32'(drive_enable));
		wr(4'hc, 32'h3f);
		rdc(4'hc, 32'h0);
		rdc(4'h0, 32'h10);
		close_out();
	end
endmodule : mst_translator_test
